/* File: rtl/sbsp_burst_ctr.sv */
// Two-bit burst address counter with linear or interleaved order
`timescale 1ns/100ps
module sbsp_burst_ctr
  import sbsp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [CNT_W-1:0] load_val_i,
  input wire logic step_i,
  input wire logic order_i,
  output logic [CNT_W-1:0] cur_o,
  output logic [CNT_W-1:0] next_o
);

  logic [CNT_W-1:0] start_q;
  logic [CNT_W-1:0] seq_q;
  logic [CNT_W-1:0] seq_n;

  assign seq_n = seq_q + CNT_ONE;

  // Two-bit sums wrap on their own, so the burst stays inside its block
  assign cur_o = (order_i == ORDER_INTERLEAVED) ? (start_q ^ seq_q)
                                                 : (start_q + seq_q);
  assign next_o = (order_i == ORDER_INTERLEAVED) ? (start_q ^ seq_n)
                                                  : (start_q + seq_n);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_q <= CNT_RST;
      seq_q <= CNT_RST;
    end else if (load_i) begin
      start_q <= load_val_i;
      seq_q <= CNT_RST;
    end else if (step_i) begin
      seq_q <= seq_n;
    end
  end

endmodule : sbsp_burst_ctr

/* File: rtl/sbsp_host_end.sv */
// Host end: issues four-beat or single bursts on the pin interface
`timescale 1ns/100ps
module sbsp_host_end
  import sbsp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic order_select_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_write_i,
  input wire logic req_burst_i,
  input wire logic req_use_proc_i,
  input wire logic [LANES-1:0] req_byte_en_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [BURST_LEN*DATA_W-1:0] req_wdata_i,
  output logic [DATA_W-1:0] rdata_o,
  output logic rdata_valid_o,
  sbsp_if.host_mp bus
);

  sbsp_host_state_t st_q;
  logic [CNT_W-1:0] beat_q;
  logic [CNT_W-1:0] last_q;
  logic wr_q;
  logic [BURST_LEN*DATA_W-1:0] wdata_q;
  logic [1:0] cap_q;
  logic ready_q;
  logic take;

  assign take = (st_q == SBSP_H_IDLE) && req_valid_i;

  // The strap passes straight through and must not change in service
  assign bus.order_select = order_select_i;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= SBSP_H_IDLE;
      beat_q <= CNT_RST;
      last_q <= CNT_RST;
      wr_q <= 1'b0;
      wdata_q <= '0;
    end else begin
      unique case (st_q)
        SBSP_H_IDLE: begin
          if (take) begin
            st_q <= SBSP_H_RUN;
            beat_q <= CNT_RST;
            last_q <= req_burst_i ? LAST_BEAT : CNT_RST;
            wr_q <= req_write_i;
            wdata_q <= req_wdata_i;
          end
        end
        SBSP_H_RUN: begin
          if (beat_q == last_q) begin
            st_q <= SBSP_H_DESEL;
          end else begin
            beat_q <= beat_q + CNT_ONE;
            wdata_q <= wdata_q >> DATA_W;
          end
        end
        SBSP_H_DESEL: begin
          st_q <= SBSP_H_IDLE;
        end
      endcase
    end
  end

  // Pin drive, all from flip-flops
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus.addr_in <= ADDR_RST;
      bus.ctrl_addr_strobe_n <= 1'b1;
      bus.proc_addr_strobe_n <= 1'b1;
      bus.burst_step_n <= 1'b1;
      bus.chip_en_primary_n <= 1'b1;
      bus.chip_en_depth_hi <= 1'b0;
      bus.chip_en_depth_lo_n <= 1'b1;
      bus.all_lanes_write_n <= 1'b1;
      bus.lane_write_en_n <= 1'b1;
      bus.lane_write_sel_n <= LANES_ALL;
      bus.out_en_n <= 1'b1;
      bus.host_data <= DATA_RST;
      bus.host_data_oe <= 1'b0;
    end else if (take) begin
      bus.addr_in <= req_addr_i;
      bus.ctrl_addr_strobe_n <= req_write_i || !req_use_proc_i ? 1'b0 : 1'b1;
      bus.proc_addr_strobe_n <= req_write_i || !req_use_proc_i ? 1'b1 : 1'b0;
      bus.burst_step_n <= 1'b1;
      bus.chip_en_primary_n <= 1'b0;
      bus.chip_en_depth_hi <= 1'b1;
      bus.chip_en_depth_lo_n <= 1'b0;
      // Full-width writes use global write, partial ones the lane pins
      bus.all_lanes_write_n <= !(req_write_i && req_byte_en_i == LANES_ALL);
      bus.lane_write_en_n <= !(req_write_i && req_byte_en_i != LANES_ALL);
      bus.lane_write_sel_n <= ~req_byte_en_i;
      bus.out_en_n <= req_write_i;
      bus.host_data <= req_wdata_i[DATA_W-1:0];
      bus.host_data_oe <= req_write_i;
    end else if (st_q == SBSP_H_RUN && beat_q != last_q) begin
      bus.ctrl_addr_strobe_n <= 1'b1;
      bus.proc_addr_strobe_n <= 1'b1;
      bus.burst_step_n <= 1'b0;
      bus.host_data <= wdata_q[2*DATA_W-1:DATA_W];
    end else if (st_q == SBSP_H_RUN) begin
      // Closing deselect cycle releases the memory between bursts
      bus.ctrl_addr_strobe_n <= 1'b0;
      bus.proc_addr_strobe_n <= 1'b1;
      bus.burst_step_n <= 1'b1;
      bus.chip_en_primary_n <= 1'b1;
      bus.all_lanes_write_n <= 1'b1;
      bus.lane_write_en_n <= 1'b1;
      bus.lane_write_sel_n <= LANES_ALL;
      bus.out_en_n <= wr_q;
      bus.host_data_oe <= 1'b0;
    end else begin
      bus.ctrl_addr_strobe_n <= 1'b1;
      bus.out_en_n <= 1'b1;
    end
  end

  // The memory takes a beat one edge after launch and its word flows out after that edge,
  // so the bus is sampled two edges after launch
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cap_q <= 2'h0;
      rdata_o <= DATA_RST;
      rdata_valid_o <= 1'b0;
    end else begin
      cap_q <= {cap_q[0], (take && !req_write_i)
                || (st_q == SBSP_H_RUN && !wr_q && beat_q != last_q)};
      rdata_valid_o <= cap_q[1];
      if (cap_q[1]) begin
        rdata_o <= bus.data_lane_io;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= (st_q == SBSP_H_DESEL) || (st_q == SBSP_H_IDLE && !req_valid_i);
    end
  end

  assign req_ready_o = ready_q;

endmodule : sbsp_host_end

/* File: rtl/sbsp_if.sv */
// Pin-level connection between the memory end and the host end
`timescale 1ns/100ps
interface sbsp_if
  import sbsp_pkg::*;
();
  logic [ADDR_W-1:0] addr_in;
  logic ctrl_addr_strobe_n;
  logic proc_addr_strobe_n;
  logic burst_step_n;
  logic order_select;
  logic chip_en_primary_n;
  logic chip_en_depth_hi;
  logic chip_en_depth_lo_n;
  logic all_lanes_write_n;
  logic lane_write_en_n;
  logic [LANES-1:0] lane_write_sel_n;
  logic out_en_n;
  logic [DATA_W-1:0] host_data;
  logic host_data_oe;
  logic [DATA_W-1:0] dev_data;
  logic dev_data_oe;
  logic [DATA_W-1:0] data_lane_io;

  // Resolved data bus level; an undriven bus reads as all ones
  assign data_lane_io = dev_data_oe ? dev_data : (host_data_oe ? host_data : '1);

  modport mem_mp (
    input addr_in, ctrl_addr_strobe_n, proc_addr_strobe_n, burst_step_n,
    input order_select, chip_en_primary_n, chip_en_depth_hi, chip_en_depth_lo_n,
    input all_lanes_write_n, lane_write_en_n, lane_write_sel_n, out_en_n,
    input data_lane_io,
    output dev_data, dev_data_oe
  );

  modport host_mp (
    output addr_in, ctrl_addr_strobe_n, proc_addr_strobe_n, burst_step_n,
    output order_select, chip_en_primary_n, chip_en_depth_hi, chip_en_depth_lo_n,
    output all_lanes_write_n, lane_write_en_n, lane_write_sel_n, out_en_n,
    output host_data, host_data_oe,
    input data_lane_io
  );

endinterface : sbsp_if

/* File: rtl/sbsp_mem_end.sv */
// Memory end: synchronous flow-through burst static memory on the pin interface
`timescale 1ns/100ps
module sbsp_mem_end
  import sbsp_pkg::*;
#(
  parameter int MEM_AW = ADDR_W
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  sbsp_if.mem_mp bus,
  output logic active_o,
  output logic write_o
);

  localparam int DEPTH = 1 << MEM_AW;

  // Lane mask of a cycle from the three write controls
  function automatic logic [LANES-1:0] lane_mask(
    input logic gw_n,
    input logic we_n,
    input logic [LANES-1:0] sel_n
  );
    logic [LANES-1:0] m;
    m = LANES_NONE;
    if (!gw_n) begin
      m = LANES_ALL;
    end else if (!we_n) begin
      m = ~sel_n;
    end
    return m;
  endfunction : lane_mask

  sbsp_mode_t mode_q;
  sbsp_mode_t mode_d;
  logic [UPPER_W-1:0] upper_q;
  logic proc_take;
  logic ctrl_take;
  logic strobe;
  logic selected;
  logic step;
  logic [LANES-1:0] lanes;
  logic [LANES-1:0] wr_en;
  logic [CNT_W-1:0] cnt_cur;
  logic [CNT_W-1:0] cnt_next;
  logic [ADDR_W-1:0] addr_d;
  logic [MEM_AW-1:0] idx;
  logic [DATA_W-1:0] rd_word;
  logic active_q;
  logic write_q;

  // A processor strobe only counts while the primary enable is low
  assign proc_take = !bus.proc_addr_strobe_n && !bus.chip_en_primary_n;

  // The controller strobe acts whenever the processor strobe was not taken
  assign ctrl_take = !bus.ctrl_addr_strobe_n && !proc_take;

  assign strobe = proc_take || ctrl_take;

  assign selected = !bus.chip_en_primary_n
                    && bus.chip_en_depth_hi
                    && !bus.chip_en_depth_lo_n;

  assign lanes = lane_mask(bus.all_lanes_write_n, bus.lane_write_en_n,
                           bus.lane_write_sel_n);

  // Cycle type decided at the edge from what is sampled there
  always_comb begin
    mode_d = mode_q;
    if (strobe) begin
      if (!selected) begin
        mode_d = SBSP_DESEL;
      end else if (proc_take) begin
        // Write controls are not looked at on a processor-started cycle
        mode_d = SBSP_READ;
      end else if (lanes != LANES_NONE) begin
        mode_d = SBSP_WRITE;
      end else begin
        mode_d = SBSP_READ;
      end
    end else if (mode_q != SBSP_DESEL) begin
      mode_d = (lanes != LANES_NONE) ? SBSP_WRITE : SBSP_READ;
    end
  end

  // Advance is ignored while deselected and on any strobe cycle
  assign step = !strobe && (mode_q != SBSP_DESEL) && !bus.burst_step_n;

  sbsp_burst_ctr u_ctr (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .load_i(strobe && selected),
    .load_val_i(bus.addr_in[CNT_W-1:0]),
    .step_i(step),
    .order_i(bus.order_select),
    .cur_o(cnt_cur),
    .next_o(cnt_next)
  );

  // Address used by this edge: external on a strobe, else next or current
  always_comb begin
    if (strobe) begin
      addr_d = bus.addr_in;
    end else if (step) begin
      addr_d = {upper_q, cnt_next};
    end else begin
      addr_d = {upper_q, cnt_cur};
    end
  end

  assign idx = addr_d[MEM_AW-1:0];

  assign wr_en = (mode_d == SBSP_WRITE) ? lanes : LANES_NONE;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_q <= SBSP_DESEL;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Upper bits only move on a new address, never during a burst
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      upper_q <= UPPER_RST;
    end else if (strobe && selected) begin
      upper_q <= bus.addr_in[ADDR_W-1:CNT_W];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      active_q <= 1'b0;
      write_q <= 1'b0;
    end else begin
      active_q <= (mode_d != SBSP_DESEL);
      write_q <= (mode_d == SBSP_WRITE);
    end
  end

  assign active_o = active_q;
  assign write_o = write_q;

  // One storage array per lane keeps each lane with a single writer
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [LANE_W-1:0] mem [DEPTH];
    logic [LANE_W-1:0] rd_q;

    always_ff @(posedge core_clk_i) begin
      if (wr_en[g]) begin
        mem[idx] <= bus.data_lane_io[g*LANE_W +: LANE_W];
      end
    end

    // Read data follows the address of the edge, giving flow-through timing
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        rd_q <= DATA_RST[LANE_W-1:0];
      end else if (mode_d == SBSP_READ) begin
        rd_q <= mem[idx];
      end
    end

    assign rd_word[g*LANE_W +: LANE_W] = rd_q;
  end

  assign bus.dev_data = rd_word;

  // Output enable is not sampled; it gates the drive directly
  assign bus.dev_data_oe = (mode_q == SBSP_READ) && !bus.out_en_n;

endmodule : sbsp_mem_end

/* File: rtl/sbsp_pkg.sv */
// Shared constants and types for the synchronous burst static memory port
package sbsp_pkg;

  localparam int ADDR_W = 18;
  localparam int LANE_W = 9;
  localparam int LANES = 2;
  localparam int DATA_W = LANE_W * LANES;
  localparam int CNT_W = 2;
  localparam int BURST_LEN = 4;
  localparam int UPPER_W = ADDR_W - CNT_W;

  // Burst counter positions and reset values
  localparam int CNT_LSB = 0;
  localparam logic [CNT_W-1:0] CNT_RST = 2'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 2'h1;
  localparam logic [CNT_W-1:0] LAST_BEAT = 2'h3;
  localparam logic [UPPER_W-1:0] UPPER_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
  localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;

  // Static burst order strap levels
  localparam logic ORDER_LINEAR = 1'b0;
  localparam logic ORDER_INTERLEAVED = 1'b1;

  // Lane write masks
  localparam logic [LANES-1:0] LANES_NONE = 2'h0;
  localparam logic [LANES-1:0] LANES_ALL = 2'h3;

  typedef enum logic [1:0] {
    SBSP_DESEL,
    SBSP_READ,
    SBSP_WRITE
  } sbsp_mode_t;

  typedef enum logic [1:0] {
    SBSP_H_IDLE,
    SBSP_H_RUN,
    SBSP_H_DESEL
  } sbsp_host_state_t;

endpackage : sbsp_pkg

/* File: test/sbsp_link_asserts.sv */
// Pin-level checks of the memory end on the joined link
`timescale 1ns/100ps
module sbsp_link_asserts
  import sbsp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ctrl_addr_strobe_n,
  input wire logic proc_addr_strobe_n,
  input wire logic chip_en_primary_n,
  input wire logic chip_en_depth_hi,
  input wire logic chip_en_depth_lo_n,
  input wire logic all_lanes_write_n,
  input wire logic lane_write_en_n,
  input wire logic [LANES-1:0] lane_write_sel_n,
  input wire logic out_en_n,
  input wire logic dev_data_oe
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic sel_all;
  logic wr_req;
  logic take;
  assign sel_all = !chip_en_primary_n && chip_en_depth_hi && !chip_en_depth_lo_n;
  assign wr_req = !all_lanes_write_n || (!lane_write_en_n && !(&lane_write_sel_n));
  // The processor strobe only counts while the primary enable selects
  assign take = !ctrl_addr_strobe_n || (!proc_addr_strobe_n && !chip_en_primary_n);
  sequence s_ctrl_take;
    !ctrl_addr_strobe_n && proc_addr_strobe_n;
  endsequence
  sequence s_proc_take;
    !proc_addr_strobe_n && !chip_en_primary_n;
  endsequence
  oe_gate_a: assert property (dev_data_oe |-> !out_en_n)
    else $error("data driven with output enable high");
  desel_pri_a: assert property (!ctrl_addr_strobe_n && chip_en_primary_n |=> !dev_data_oe)
    else $error("controller strobe with primary enable high did not deselect");
  depth_hi_a: assert property (take && !chip_en_depth_hi |=> !dev_data_oe)
    else $error("low depth enable did not deselect");
  depth_lo_a: assert property (take && chip_en_depth_lo_n |=> !dev_data_oe)
    else $error("high depth enable did not deselect");
  write_quiet_a: assert property (s_ctrl_take ##0 sel_all && wr_req |=> !dev_data_oe)
    else $error("memory drove data in a write cycle");
  read_start_a: assert property (s_ctrl_take ##0 sel_all && !wr_req ##1 !out_en_n
    |-> dev_data_oe)
    else $error("controller read start did not drive data");
  proc_read_a: assert property (s_proc_take ##0 sel_all ##1 !out_en_n |-> dev_data_oe)
    else $error("processor read start did not drive data");
  write_oe_off_a: assert property (s_ctrl_take ##0 sel_all && wr_req
    |-> out_en_n ##1 out_en_n)
    else $error("output enable low around a write");
endmodule : sbsp_link_asserts

/* File: test/test_sync_burst_sram_port.sv */
// Bench: host end against memory end, plus a memory end driven pin by pin
`timescale 1ns/100ps
module test_sync_burst_sram_port
  import sbsp_pkg::*;
;
  // Pin words: ctrl, proc, step, pri_n, hi, lo_n, all_n, lane_en_n, sel_n[1:0]
  localparam logic [9:0] WR = 10'h1A7, RD = 10'h1AF, WS = 10'h327, RS = 10'h32F, HOLD = 10'h3AF;
  localparam logic [9:0] DES = 10'h1EF, PIGN = 10'h2EF, PRD = 10'h2A7, NHI = 10'h18F, NLO = 10'h1BF;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic rq_v = 1'b0, rq_w = 1'b0, rq_b = 1'b0, rq_p = 1'b0, rdy, rv, act_b, wr_b;
  logic [LANES-1:0] rq_be = LANES_ALL;
  logic [ADDR_W-1:0] rq_a = ADDR_RST;
  logic [BURST_LEN*DATA_W-1:0] rq_d = '0;
  logic [DATA_W-1:0] rd_a;
  logic [DATA_W-1:0] ma [64];
  logic [DATA_W-1:0] mb [64];
  int errors = 0, check_count = 0, cycles = 0;
  sbsp_if if_a ();
  sbsp_if if_b ();
  always #12.5 core_clk_i = ~core_clk_i;
  sbsp_host_end sbsp_host_end_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .order_select_i(ORDER_LINEAR), .req_valid_i(rq_v), .req_ready_o(rdy), .req_write_i(rq_w),
    .req_burst_i(rq_b), .req_use_proc_i(rq_p), .req_byte_en_i(rq_be), .req_addr_i(rq_a),
    .req_wdata_i(rq_d), .rdata_o(rd_a), .rdata_valid_o(rv), .bus(if_a));
  sbsp_mem_end #(.MEM_AW(6)) sbsp_mem_end_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .bus(if_a), .active_o(), .write_o());
  sbsp_mem_end #(.MEM_AW(6)) sbsp_mem_end_b_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .bus(if_b), .active_o(act_b), .write_o(wr_b));
  sbsp_link_asserts sbsp_link_asserts_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .ctrl_addr_strobe_n(if_a.ctrl_addr_strobe_n), .proc_addr_strobe_n(if_a.proc_addr_strobe_n),
    .chip_en_primary_n(if_a.chip_en_primary_n), .chip_en_depth_hi(if_a.chip_en_depth_hi),
    .chip_en_depth_lo_n(if_a.chip_en_depth_lo_n), .all_lanes_write_n(if_a.all_lanes_write_n),
    .lane_write_en_n(if_a.lane_write_en_n), .lane_write_sel_n(if_a.lane_write_sel_n),
    .out_en_n(if_a.out_en_n), .dev_data_oe(if_a.dev_data_oe));
  task automatic cmp(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wrap_up();
    if (errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  // Host drives the bus only with output enable high, so writes never fight the memory
  task automatic put(input logic [9:0] c, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic rd);
    {if_b.ctrl_addr_strobe_n, if_b.proc_addr_strobe_n, if_b.burst_step_n,
      if_b.chip_en_primary_n, if_b.chip_en_depth_hi, if_b.chip_en_depth_lo_n,
      if_b.all_lanes_write_n, if_b.lane_write_en_n, if_b.lane_write_sel_n} = c;
    {if_b.addr_in, if_b.host_data, if_b.out_en_n, if_b.host_data_oe} = {a, d, !rd, !rd};
  endtask : put
  task automatic pin(input logic [9:0] c, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic rd);
    @(negedge core_clk_i);
    put(c, a, d, rd);
    @(posedge core_clk_i);
  endtask : pin
  // Flow-through: the word of the edge's address is on the bus shortly after the edge
  task automatic look(input logic [DATA_W-1:0] e);
    #5;
    cmp(if_b.data_lane_io, e);
  endtask : look
  task automatic req(input logic w, input logic b, input logic p, input logic [1:0] be,
                     input logic [5:0] a, input logic [BURST_LEN*DATA_W-1:0] d);
    logic [5:0] x;
    do @(negedge core_clk_i); while (rdy !== 1'b1);
    {rq_v, rq_w, rq_b, rq_p, rq_be, rq_a, rq_d} = {1'b1, w, b, p, be, 12'h000, a, d};
    @(negedge core_clk_i);
    rq_v = 1'b0;
    for (int k = 0; k < (b ? 4 : 1); k++) begin
      x = {a[5:2], a[1:0] + 2'(k)};
      if (w) begin
        ma[x] = {be[1] ? d[k*DATA_W+LANE_W +: LANE_W] : ma[x][17:9],
                 be[0] ? d[k*DATA_W +: LANE_W] : ma[x][8:0]};
      end else begin
        do @(negedge core_clk_i); while (rv !== 1'b1);
        cmp(rd_a, ma[x]);
      end
    end
  endtask : req
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      $display("mismatch at %0t: run did not finish", $time);
      wrap_up();
    end
  end
  initial begin
    put(10'h3EF, ADDR_RST, DATA_RST, 1'b1);
    if_b.order_select = ORDER_INTERLEAVED;
    repeat (4) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    req(1'b1, 1'b1, 1'b0, LANES_ALL, 6'h05, {18'h35A03, 18'h2A502, 18'h15A01, 18'h0A500});
    req(1'b0, 1'b1, 1'b0, LANES_ALL, 6'h05, '0);
    req(1'b0, 1'b1, 1'b1, LANES_ALL, 6'h06, '0);
    req(1'b1, 1'b0, 1'b0, 2'h1, 6'h07, {54'h0, 18'h3FFFF});
    req(1'b1, 1'b0, 1'b0, 2'h2, 6'h04, {54'h0, 18'h3FFFF});
    req(1'b0, 1'b1, 1'b0, LANES_ALL, 6'h07, '0);
    for (int k = 0; k < 4; k++) begin
      pin(k == 0 ? WR : WS, 18'h00012, 18'h2A5A0 ^ 18'(k), 1'b0);
      mb[6'h10 | 6'(2 ^ k)] = 18'h2A5A0 ^ 18'(k);
    end
    for (int k = 0; k < 4; k++) begin
      pin(k == 0 ? RD : RS, 18'h00012, DATA_RST, 1'b1);
      look(mb[6'h10 | 6'(2 ^ k)]);
    end
    pin(HOLD, 18'h00012, DATA_RST, 1'b1);
    look(mb[6'h11]);
    pin(PIGN, 18'h00030, DATA_RST, 1'b1);
    look(mb[6'h11]);
    @(negedge core_clk_i);
    if_b.out_en_n = 1'b1;
    #1 cmp(if_b.data_lane_io, '1);
    pin(DES, 18'h00010, DATA_RST, 1'b1);
    look('1);
    cmp(DATA_W'(act_b), DATA_RST);
    pin(RS, 18'h00010, DATA_RST, 1'b1);
    look('1);
    pin(PRD, 18'h00013, DATA_RST, 1'b1);
    look(mb[6'h13]);
    cmp(DATA_W'(act_b), 18'h00001);
    pin(NHI, 18'h00010, DATA_RST, 1'b1);
    look('1);
    pin(RD, 18'h00010, DATA_RST, 1'b1);
    look(mb[6'h10]);
    pin(NLO, 18'h00010, DATA_RST, 1'b1);
    look('1);
    pin(10'h1AA, 18'h00010, 18'h3FFFF, 1'b0);
    mb[6'h10][8:0] = 9'h1FF;
    pin(10'h1A9, 18'h00011, 18'h00000, 1'b0);
    mb[6'h11][17:9] = 9'h000;
    #5 cmp(DATA_W'(wr_b), 18'h00001);
    pin(10'h1AB, 18'h00010, 18'h00000, 1'b0);
    #5 cmp(DATA_W'(wr_b), DATA_RST);
    pin(10'h1A2, 18'h00012, 18'h12345, 1'b0);
    mb[6'h12] = 18'h12345;
    for (int k = 0; k < 3; k++) begin
      pin(RD, 18'h00010 + 18'(k), DATA_RST, 1'b1);
      look(mb[6'h10 + 6'(k)]);
    end
    wrap_up();
  end
endmodule : test_sync_burst_sram_port
